// ==== adc_ctrl_defines.svh ====
// Constants for the converter conversion and serial readout controller.
// Assumes a 50 MHz reference clock and the register layout chosen for this block.
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define REF_CLK_NS        20
`define OSC_START_NS      1000000
`define OSC_START_CYC     ((`OSC_START_NS + `REF_CLK_NS - 1) / `REF_CLK_NS)
`define REF_CLK_KHZ       50000
`define INT_OSC_KHZ       4920
`define INT_OSC_DIV       (`REF_CLK_KHZ / `INT_OSC_KHZ)
`define RESET_ONES        6'h28
`define SINC_ORDER_SHIFT  2

// ----------------------------------------------------------------------------
// Communications byte and register addresses
// ----------------------------------------------------------------------------
`define COMMS_WEN_BIT     7
`define COMMS_RW_BIT      6
`define COMMS_ADDR_HI     5
`define COMMS_ADDR_LO     3
`define COMMS_CREAD_BIT   2
`define CMD_CREAD_ENTER   8'h5c
`define CMD_CREAD_EXIT    8'h58
`define ADDR_STATUS       3'h0
`define ADDR_MODE         3'h1
`define ADDR_CONFIG       3'h2
`define ADDR_DATA         3'h3

// ----------------------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------------------
`define MODE_SEL_HI       23
`define MODE_SEL_LO       21
`define MODE_APPEND_BIT   20
`define MODE_CLKSRC_HI    19
`define MODE_CLKSRC_LO    18
`define MODE_PARITY_BIT   13
`define MODE_FILT_HI      9
`define MODE_FILT_LO      0
`define CONF_CHEN_HI      15
`define CONF_CHEN_LO      8
`define MODE_RESET        24'h080060
`define CONF_RESET        24'h000100
`define SEL_CONT          3'h0
`define SEL_SINGLE        3'h1
`define SEL_IDLE          3'h2
`define SEL_PDOWN         3'h3
`define CSRC_INT          2'h0
`define CSRC_INT_OUT      2'h1
`define CSRC_XTAL         2'h2
`define CSRC_EXT          2'h3
`define LEN_STATUS        6'h08
`define LEN_WORD          6'h18
`define LEN_WORD_STAT     6'h20

`endif

// ==== adc_ctrl_pkg.sv ====
// Types shared by the converter readout controller.
// Assumes nothing of its surroundings.
`default_nettype none
package adc_ctrl_pkg;
  typedef enum logic [1:0] {SR_CMD, SR_WRITE, SR_READ} ser_state_t;
  typedef enum logic [2:0] {CV_OFF, CV_WAKE, CV_SETTLE, CV_FETCH, CV_UPDATE} conv_state_t;
endpackage : adc_ctrl_pkg
`default_nettype wire

// ==== adc_readout_ctrl.sv ====
// Conversion flow and serial readout control of a multichannel converter.
// Assumes host pins are asynchronous and samples arrive on the ref_clk_in domain.
//
// Behaviour
// - Ready goes high before every data register update.
// - Single-conversion code powers up, converts, then powers down.
// - Wait about one millisecond for oscillator start before converting after a mode write; not after reset.
// - Single mode: ready low at completion, high after data read.
// - Data register rereadable outside continuous read, same word each time.
// - Ready high at conversion start until a valid result exists.
// - Single mode converts each enabled channel once, then powers down.
// - Data register overwritten at next completion unless a data register read is under way; old result readable meanwhile.
// - Append-status shifts status after word; low four bits give channel.
// - Continuous conversion after reset; ready cleared at each completion.
// - Continuous mode cycles enabled channels, ready pulses low per result.
// - Byte 01011100 enters continuous read; results shift out without command.
// - Continuous read words read once; unread word replaced at completion.
// - Byte 01011000 while ready low leaves continuous read; input always watched.
// - Forty consecutive ones reset all logic and registers except the internal oscillator divider; also at power-up.
// - Sync low holds modulator and filter reset, configuration kept.
// - Sync reset released on next master tick after sync rises: crystal or external clock falling edge, or internal oscillator tick.
// - Sync rise starts conversion; ready falls after full settling time.
// - Parity bit makes transmitted word plus status hold even ones.
// - Master clock from internal oscillator, crystal or external clock, optionally output.
`include "adc_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_readout_ctrl #(
  parameter int WAKE_CYC = `OSC_START_CYC,
  parameter int DEPTH    = 32
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        cs_b_in,
  input  wire logic        sclk_in,
  input  wire logic        din_in,
  input  wire logic        sync_b_in,
  input  wire logic        crystal_in_pin_in,
  input  wire logic        master_clock_io_pin_in,
  input  wire logic        sample_valid_in,
  input  wire logic [23:0] sample_data_in,
  output logic             sample_ready_out,
  output logic             dout_rdy_out,
  output logic             dout_rdy_oe_b_out,
  output logic             master_clock_io_pin_out,
  output logic             master_clock_io_pin_oe_b_out,
  output logic             filter_reset_out,
  output logic             powered_down_out,
  output logic             cont_read_out,
  output logic [3:0]       channel_out
);

  // --------------------------------------------------------------------------
  // Pin synchronisation and edges
  // --------------------------------------------------------------------------
  logic [5:0] pins_s;
  logic       cs_b_s, sclk_s, din_s, sync_b_s, xtal_s, ext_s;
  logic       sclk_d_r, xtal_d_r, ext_d_r;
  logic       sclk_rise, sclk_fall;

  pin_sync #(.W(6)) u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .pin_in     ({cs_b_in, sclk_in, din_in, sync_b_in, crystal_in_pin_in, master_clock_io_pin_in}),
    .sync_out   (pins_s)
  );
  assign {cs_b_s, sclk_s, din_s, sync_b_s, xtal_s, ext_s} = pins_s;

  always_ff @(posedge ref_clk_in) begin
    sclk_d_r <= sclk_s;
    xtal_d_r <= xtal_s;
    ext_d_r  <= ext_s;
  end
  assign sclk_rise = !cs_b_s && sclk_s && !sclk_d_r;
  assign sclk_fall = !cs_b_s && !sclk_s && sclk_d_r;

  // --------------------------------------------------------------------------
  // Reset and registers
  // --------------------------------------------------------------------------
  logic        soft_rst_r;
  logic        rst_b;
  logic [23:0] mode_r, conf_r, data_r;
  logic [3:0]  data_ch_r;
  logic        rdy_b_r;
  logic [2:0]  mode_sel;
  logic [1:0]  clk_src;
  logic [7:0]  ch_en;
  logic        append_status_enable, parity_enable;
  logic        mode_wr;

  assign rst_b = rst_b_in && !soft_rst_r;

  assign mode_sel             = mode_r[`MODE_SEL_HI:`MODE_SEL_LO];
  assign clk_src              = mode_r[`MODE_CLKSRC_HI:`MODE_CLKSRC_LO];
  assign append_status_enable = mode_r[`MODE_APPEND_BIT];
  assign parity_enable        = mode_r[`MODE_PARITY_BIT];
  assign ch_en                = conf_r[`CONF_CHEN_HI:`CONF_CHEN_LO];

  // --------------------------------------------------------------------------
  // Master clock selection
  // --------------------------------------------------------------------------
  logic [3:0] osc_div_r;
  logic       osc_tick, osc_level_r, master_tick;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      osc_div_r   <= 4'h0;
      osc_level_r <= 1'b0;
    end else if (osc_div_r == 4'(`INT_OSC_DIV - 1)) begin
      osc_div_r   <= 4'h0;
      osc_level_r <= !osc_level_r;
    end else begin
      osc_div_r   <= osc_div_r + 4'h1;
    end
  end
  assign osc_tick = osc_div_r == 4'(`INT_OSC_DIV - 1);

  always_comb begin
    unique case (clk_src)
      `CSRC_XTAL: master_tick = !xtal_s && xtal_d_r;
      `CSRC_EXT:  master_tick = !ext_s && ext_d_r;
      default:    master_tick = osc_tick;
    endcase
  end
  assign master_clock_io_pin_out      = osc_level_r;
  assign master_clock_io_pin_oe_b_out = clk_src != `CSRC_INT_OUT;

  // --------------------------------------------------------------------------
  // Sync hold
  // --------------------------------------------------------------------------
  logic hold_r;

  // release on master tick: crystal or external clock falling edge, or any internal oscillator tick
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b) begin
      hold_r <= 1'b0;
    end else if (!sync_b_s) begin
      hold_r <= 1'b1;
    end else if (master_tick) begin
      hold_r <= 1'b0;
    end
  end
  assign filter_reset_out = hold_r;

  // --------------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------------
  adc_ctrl_pkg::conv_state_t cv_r;
  sample_stream_if #(.W(24)) smp_if ();
  logic [16:0] wake_cnt_r;
  logic [11:0] settle_cnt_r;
  logic [11:0] settle_len;
  logic [2:0]  ch_r;
  logic [23:0] pend_r;
  logic        single_r, rd_data_busy, cread_r, upd_pulse, rd_data_done;
  logic [3:0]  nxt;

  sample_fifo #(.W(24), .DEPTH(DEPTH)) u_fifo (
    .ref_clk_in   (ref_clk_in),
    .rst_b_in     (rst_b),
    .in_valid_in  (sample_valid_in),
    .in_data_in   (sample_data_in),
    .in_ready_out (sample_ready_out),
    .out_if       (smp_if)
  );
  assign smp_if.ready = cv_r == adc_ctrl_pkg::CV_FETCH;

  // Returns the next enabled channel after cur, bit 3 set on wrap.
  function automatic logic [3:0] next_ch(input logic [7:0] en, input logic [2:0] cur);
    logic [3:0] res;
    res = {1'b1, cur};
    for (int i = 7; i >= 1; i--) begin
      if (en[3'(int'(cur) + i)]) begin
        res = {(int'(cur) + i) > 7, 3'(int'(cur) + i)};
      end
    end
    return res;
  endfunction : next_ch

  assign nxt        = next_ch(ch_en, ch_r);
  assign settle_len = {mode_r[`MODE_FILT_HI:`MODE_FILT_LO], 2'b00} << (`SINC_ORDER_SHIFT - 2);
  assign upd_pulse  = cv_r == adc_ctrl_pkg::CV_UPDATE;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b || mode_wr) begin
      cv_r         <= adc_ctrl_pkg::CV_OFF;
      wake_cnt_r   <= '0;
      settle_cnt_r <= '0;
      ch_r         <= 3'h7;
      single_r     <= 1'b0;
      pend_r       <= '0;
    end else begin
      unique case (cv_r)
        adc_ctrl_pkg::CV_OFF: begin
          ch_r <= 3'(next_ch(ch_en, 3'h7));
          if (mode_sel == `SEL_CONT) begin
            cv_r <= adc_ctrl_pkg::CV_SETTLE;
          end
          if (single_r) begin
            single_r <= 1'b0;
            cv_r     <= adc_ctrl_pkg::CV_WAKE;
          end
        end
        adc_ctrl_pkg::CV_WAKE: begin
          wake_cnt_r <= wake_cnt_r + 17'h1;
          if (wake_cnt_r == 17'(WAKE_CYC - 1)) begin
            cv_r <= adc_ctrl_pkg::CV_SETTLE;
          end
        end
        adc_ctrl_pkg::CV_SETTLE: begin
          if (hold_r) begin
            settle_cnt_r <= '0;
          end else if (master_tick) begin
            settle_cnt_r <= settle_cnt_r + 12'h1;
            if (settle_cnt_r + 12'h1 >= settle_len) begin
              cv_r <= adc_ctrl_pkg::CV_FETCH;
            end
          end
        end
        adc_ctrl_pkg::CV_FETCH: begin
          settle_cnt_r <= '0;
          if (smp_if.valid) begin
            pend_r <= smp_if.data;
            cv_r   <= adc_ctrl_pkg::CV_UPDATE;
          end
        end
        adc_ctrl_pkg::CV_UPDATE: begin
          ch_r <= nxt[2:0];
          // single mode stops after last channel
          if (mode_sel == `SEL_SINGLE && nxt[3]) begin
            cv_r <= adc_ctrl_pkg::CV_OFF;
          end else begin
            cv_r <= adc_ctrl_pkg::CV_SETTLE;
          end
        end
        default: cv_r <= adc_ctrl_pkg::CV_OFF;
      endcase
    end
    if (rst_b && mode_wr) begin
      single_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b) begin
      data_r    <= '0;
      data_ch_r <= '0;
    end else if (upd_pulse && (cread_r || !rd_data_busy)) begin
      data_r    <= pend_r;
      data_ch_r <= {1'b0, ch_r};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b) begin
      rdy_b_r <= 1'b1;
    end else if (cv_r == adc_ctrl_pkg::CV_FETCH || mode_wr) begin
      rdy_b_r <= 1'b1;
    end else if (upd_pulse && (cread_r || !rd_data_busy)) begin
      rdy_b_r <= 1'b0;
    end else if (rd_data_done) begin
      rdy_b_r <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Serial interface
  // --------------------------------------------------------------------------
  adc_ctrl_pkg::ser_state_t sr_r;
  logic [7:0]  in_sh_r;
  logic [3:0]  cmd_cnt_r;
  logic [5:0]  ones_r, bit_cnt_r, len_r;
  logic [31:0] out_sh_r;
  logic [23:0] wr_sh_r;
  logic [2:0]  addr_r;
  logic [7:0]  status;
  logic [7:0]  cmd;
  logic        cmd_done, par, par_cr;
  logic        logic_unused;

  // even parity over word and status
  assign par    = parity_enable && append_status_enable && ^{data_r, rdy_b_r, data_ch_r};
  assign par_cr = parity_enable && append_status_enable && ^{pend_r, ch_r};
  assign status = {rdy_b_r, 2'b00, par, data_ch_r};
  assign cmd          = {in_sh_r[6:0], din_s};
  assign cmd_done     = sclk_rise && cmd_cnt_r == 4'h7 && (sr_r == adc_ctrl_pkg::SR_CMD || cread_r);
  assign rd_data_done = sr_r == adc_ctrl_pkg::SR_READ && sclk_fall && bit_cnt_r + 6'h1 == len_r
                        && addr_r == `ADDR_DATA;
  assign rd_data_busy = sr_r == adc_ctrl_pkg::SR_READ && addr_r == `ADDR_DATA;
  assign mode_wr      = sr_r == adc_ctrl_pkg::SR_WRITE && sclk_rise && bit_cnt_r + 6'h1 == len_r
                        && addr_r == `ADDR_MODE;
  assign logic_unused = ^in_sh_r[7];

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in || soft_rst_r) begin
      ones_r     <= '0;
      soft_rst_r <= 1'b0;
    end else if (sclk_rise) begin
      ones_r     <= din_s ? ones_r + 6'h1 : 6'h0;
      soft_rst_r <= din_s && ones_r + 6'h1 == `RESET_ONES;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b || cs_b_s) begin
      in_sh_r   <= '0;
      cmd_cnt_r <= '0;
    end else if (sclk_rise) begin
      in_sh_r   <= cmd;
      cmd_cnt_r <= (cmd_cnt_r == 4'h7 || (sr_r != adc_ctrl_pkg::SR_CMD && !cread_r)) ? 4'h0 : cmd_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b) begin
      cread_r <= 1'b0;
    end else if (cmd_done && cmd == `CMD_CREAD_ENTER) begin
      cread_r <= 1'b1;
    end else if (cmd_done && cmd == `CMD_CREAD_EXIT && cread_r && !rdy_b_r) begin
      cread_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b || (cs_b_s && !cread_r)) begin
      sr_r      <= adc_ctrl_pkg::SR_CMD;
      bit_cnt_r <= '0;
      len_r     <= `LEN_STATUS;
      addr_r    <= `ADDR_STATUS;
      out_sh_r  <= '0;
      wr_sh_r   <= '0;
    end else if (cread_r && upd_pulse) begin
      sr_r      <= adc_ctrl_pkg::SR_READ;
      bit_cnt_r <= '0;
      addr_r    <= `ADDR_DATA;
      len_r     <= append_status_enable ? `LEN_WORD_STAT : `LEN_WORD;
      out_sh_r  <= {pend_r, 1'b0, 2'b00, par_cr, 1'b0, ch_r};
    end else begin
      unique case (sr_r)
        adc_ctrl_pkg::SR_CMD: begin
          bit_cnt_r <= '0;
          if (cmd_done && !cmd[`COMMS_WEN_BIT] && !cread_r) begin
            addr_r <= cmd[`COMMS_ADDR_HI:`COMMS_ADDR_LO];
            unique case (cmd[`COMMS_ADDR_HI:`COMMS_ADDR_LO])
              `ADDR_STATUS: begin
                len_r    <= `LEN_STATUS;
                out_sh_r <= {status, 24'h000000};
              end
              `ADDR_MODE: begin
                len_r    <= `LEN_WORD;
                out_sh_r <= {mode_r, 8'h00};
              end
              `ADDR_CONFIG: begin
                len_r    <= `LEN_WORD;
                out_sh_r <= {conf_r, 8'h00};
              end
              default: begin
                len_r    <= append_status_enable ? `LEN_WORD_STAT : `LEN_WORD;
                out_sh_r <= {data_r, status};
              end
            endcase
            if (cmd[`COMMS_RW_BIT] && !cmd[`COMMS_CREAD_BIT]) begin
              sr_r <= adc_ctrl_pkg::SR_READ;
            end else if (!cmd[`COMMS_RW_BIT] && cmd[`COMMS_ADDR_HI:`COMMS_ADDR_LO] != `ADDR_STATUS
                         && cmd[`COMMS_ADDR_HI:`COMMS_ADDR_LO] != `ADDR_DATA) begin
              sr_r <= adc_ctrl_pkg::SR_WRITE;
            end
          end
        end
        adc_ctrl_pkg::SR_WRITE: begin
          if (sclk_rise) begin
            wr_sh_r   <= {wr_sh_r[22:0], din_s};
            bit_cnt_r <= bit_cnt_r + 6'h1;
            if (bit_cnt_r + 6'h1 == len_r) begin
              sr_r <= adc_ctrl_pkg::SR_CMD;
            end
          end
        end
        adc_ctrl_pkg::SR_READ: begin
          if (sclk_fall) begin
            out_sh_r  <= {out_sh_r[30:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 6'h1;
            if (bit_cnt_r + 6'h1 == len_r) begin
              sr_r <= adc_ctrl_pkg::SR_CMD;
            end
          end
        end
        default: sr_r <= adc_ctrl_pkg::SR_CMD;
      endcase
    end
  end

  // Configuration writes land at the end of the word.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b) begin
      mode_r <= `MODE_RESET;
      conf_r <= `CONF_RESET;
    end else if (sr_r == adc_ctrl_pkg::SR_WRITE && sclk_rise && bit_cnt_r + 6'h1 == len_r) begin
      if (addr_r == `ADDR_MODE) begin
        mode_r <= {wr_sh_r[22:0], din_s};
      end else begin
        conf_r <= {wr_sh_r[22:0], din_s};
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin outputs
  // --------------------------------------------------------------------------
  // pin shifts data out during a register read and follows the ready flag otherwise; driven while selected
  assign dout_rdy_out      = (sr_r == adc_ctrl_pkg::SR_READ) ? out_sh_r[31] : rdy_b_r;
  assign dout_rdy_oe_b_out = cs_b_s;
  assign powered_down_out  = cv_r == adc_ctrl_pkg::CV_OFF;
  assign cont_read_out     = cread_r;
  assign channel_out       = {1'b0, ch_r};

endmodule : adc_readout_ctrl
`default_nettype wire

// ==== adc_readout_ctrl_monitor.sv ====
// Port checks for the readout controller.
// Bound to adc_readout_ctrl.
`timescale 1ns/1ps
`default_nettype none
module adc_readout_ctrl_monitor (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic cs_b_in,
  input wire logic sync_b_in,
  input wire logic dout_rdy_out,
  input wire logic dout_rdy_oe_b_out,
  input wire logic master_clock_io_pin_out,
  input wire logic filter_reset_out,
  input wire logic powered_down_out,
  input wire logic cont_read_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence s_done;
    sync_b_in && dout_rdy_oe_b_out ##1 $fell(dout_rdy_out);
  endsequence
  property p_hold; !sync_b_in [*5] |-> filter_reset_out; endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  property p_frs; $rose(filter_reset_out) |-> !sync_b_in; endproperty
  a_frs: assert property (p_frs) else $error("bad hold");
  property p_rel; $fell(filter_reset_out) |-> sync_b_in; endproperty
  a_rel: assert property (p_rel) else $error("bad release");
  property p_osc; $changed(master_clock_io_pin_out) |=> $stable(master_clock_io_pin_out) [*8]; endproperty
  a_osc: assert property (p_osc) else $error("clock rate");
  property p_oe; $stable(cs_b_in) [*4] |-> dout_rdy_oe_b_out == cs_b_in; endproperty
  a_oe: assert property (p_oe) else $error("pin enable");
  property p_wake; $fell(powered_down_out) |-> dout_rdy_out [*8]; endproperty
  a_wake: assert property (p_wake) else $error("early ready");
  property p_cread; $rose(cont_read_out) |-> !dout_rdy_oe_b_out; endproperty
  a_cread: assert property (p_cread) else $error("bad entry");
  property p_calm; s_done |=> !dout_rdy_out [*4]; endproperty
  a_calm: assert property (p_calm) else $error("ready lost");
endmodule : adc_readout_ctrl_monitor
bind adc_readout_ctrl adc_readout_ctrl_monitor i_mon (.*);
`default_nettype wire

// ==== adc_readout_ctrl_tb.sv ====
// Bench for the readout controller.
// Assumes host_model on the serial pins.
`timescale 1ns/1ps
`default_nettype none
module adc_readout_ctrl_tb;
  localparam logic [23:0] SMP = 24'h5a3c97;
  logic ref_clk_in = 1'b0, rst_b_in = 1'b0, sync_b_in = 1'b1, crystal_in_pin_in = 1'b0, last = 1'b0;
  logic cs_b_in, sclk_in, din_in, sample_ready_out, dout_rdy_out, dout_rdy_oe_b_out, master_clock_io_pin_out;
  logic filter_reset_out, powered_down_out, cont_read_out, master_clock_io_pin_oe_b_out;
  logic [3:0] channel_out;
  logic [31:0] rd;
  int errors = 0, total_checks = 0, cyc = 0;
  wire logic master_clock_io_pin_in = crystal_in_pin_in;
  wire logic sample_valid_in = 1'b1;
  wire logic [23:0] sample_data_in = SMP;
  wire logic pin = dout_rdy_oe_b_out ? ~last : dout_rdy_out;
  initial forever #10 ref_clk_in = ~ref_clk_in;
  always #100 crystal_in_pin_in = ~crystal_in_pin_in;
  always @(posedge ref_clk_in) if (!dout_rdy_oe_b_out) last <= dout_rdy_out;
  adc_readout_ctrl #(.WAKE_CYC(20)) i_dut (.*);
  host_model i_host (.ref_clk_in(ref_clk_in), .dout_in(pin), .cs_b_out(cs_b_in), .sclk_out(sclk_in), .din_out(din_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_b(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_b
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic wait_rdy(input logic v);
    for (int n = 0; n < 20000 && dout_rdy_out !== v; n++) @(negedge ref_clk_in);
    chk_b(dout_rdy_out, v);
  endtask : wait_rdy
  task automatic wait_done();
    wait_rdy(1'b1);
    wait_rdy(1'b0);
  endtask : wait_done
  task automatic t_cont();
    wait_done();
    // read ends long before next completion
    i_host.xfer({8'h58, 32'h0}, 32, 8, rd);
    chk(rd, {8'h0, SMP});
    chk_b(dout_rdy_out, 1'b1);
    i_host.xfer({8'h58, 32'h0}, 32, 8, rd);
    chk(rd, {8'h01, SMP});
    $display("cont done");
  endtask : t_cont
  task automatic t_app();
    i_host.xfer({8'h08, 24'h142060, 8'h0}, 32, 8, rd);
    chk_b(master_clock_io_pin_oe_b_out, 1'b0);
    wait_done();
    i_host.xfer({8'h58, 32'h0}, 40, 8, rd);
    chk(rd, {SMP, 3'h0, ^SMP, 4'h0});
    i_host.xfer({40{1'b1}}, 40, 8, rd);
    chk_b(master_clock_io_pin_oe_b_out, 1'b1);
    repeat (25000) @(negedge ref_clk_in);
    $display("append done");
  endtask : t_app
  task automatic t_single();
    i_host.xfer({8'h10, 24'h000300, 8'h0}, 32, 8, rd);
    i_host.xfer({8'h08, 24'h380060, 8'h0}, 32, 8, rd);
    chk_b(powered_down_out, 1'b0);
    chk({28'h0, channel_out}, 32'h0);
    for (int n = 0; n < 20000 && powered_down_out !== 1'b1; n++) @(negedge ref_clk_in);
    chk_b(powered_down_out, 1'b1);
    chk_b(sample_ready_out, 1'b0);
    i_host.xfer({8'h58, 32'h0}, 40, 8, rd);
    chk({4'h0, rd[31:8], rd[3:0]}, {4'h0, SMP, 4'h1});
    i_host.xfer({8'h08, 24'h080060, 8'h0}, 32, 8, rd);
    $display("single done");
  endtask : t_single
  task automatic t_cread();
    i_host.xfer({8'h5c, 32'h0}, 8, 8, rd);
    chk_b(cont_read_out, 1'b1);
    wait_done();
    i_host.xfer(40'h0, 24, 0, rd);
    chk(rd, {8'h0, SMP});
    chk_b(dout_rdy_out, 1'b1);
    i_host.xfer({8'h58, 32'h0}, 8, 8, rd);
    chk_b(cont_read_out, 1'b1);
    wait_done();
    i_host.xfer({8'h58, 32'h0}, 8, 8, rd);
    chk_b(cont_read_out, 1'b0);
    $display("cread done");
  endtask : t_cread
  task automatic t_sync();
    sync_b_in = 1'b0;
    repeat (20) @(negedge ref_clk_in);
    chk_b(filter_reset_out, 1'b1);
    sync_b_in = 1'b1;
    repeat (20) @(negedge ref_clk_in);
    chk_b(filter_reset_out, 1'b0);
    wait_done();
    $display("sync done");
  endtask : t_sync
  initial begin
    repeat (2) @(negedge ref_clk_in);
    rst_b_in = 1'b1;
    t_cont();
    t_app();
    t_single();
    t_cread();
    t_sync();
    give_verdict();
  end
  always @(negedge ref_clk_in) begin
    cyc++;
    if (cyc == 100000) begin
      errors++;
      give_verdict();
    end
  end
endmodule : adc_readout_ctrl_tb
`default_nettype wire

// ==== host_model.sv ====
// Serial host driving the converter pins.
// Assumes a 20 ns reference clock; serial clock 160 ns.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic ref_clk_in,
  input  wire logic dout_in,
  output var  logic cs_b_out = 1'b1,
  output var  logic sclk_out = 1'b1,
  output var  logic din_out = 1'b0
);
  task automatic xfer(input logic [39:0] tx, input int n, input int sk, output logic [31:0] rd);
    cs_b_out = 1'b0;
    rd = {31'h0, dout_in};
    repeat (6) @(negedge ref_clk_in);
    rd = {31'h0, dout_in};
    for (int k = 0; k < n; k++) begin
      sclk_out = 1'b0;
      din_out = tx[39-k];
      repeat (4) @(negedge ref_clk_in);
      sclk_out = 1'b1;
      repeat (4) @(negedge ref_clk_in);
      if (k >= sk - 1 && k < n - 1)
        rd = {rd[30:0], dout_in};
    end
    din_out = 1'b0;
    repeat (8) @(negedge ref_clk_in);
    cs_b_out = 1'b1;
    repeat (8) @(negedge ref_clk_in);
  endtask : xfer
endmodule : host_model
`default_nettype wire

// ==== pin_sync.sv ====
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_in,
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk_in) begin
    meta_r   <= pin_in;
    sync_out <= meta_r;
  end
endmodule : pin_sync
`default_nettype wire

// ==== sample_fifo.sv ====
// Sample FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 32
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  sample_stream_if.src      out_if
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr_r;
  logic [AW:0]  rd_ptr_r;
  logic         push;
  logic         pop;

  assign in_ready_out = (wr_ptr_r - rd_ptr_r) != (AW+1)'(DEPTH);
  assign out_if.valid = wr_ptr_r != rd_ptr_r;
  assign out_if.data  = mem[rd_ptr_r[AW-1:0]];
  assign push         = in_valid_in && in_ready_out;
  assign pop          = out_if.valid && out_if.ready;

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
      rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
    end
  end
endmodule : sample_fifo
`default_nettype wire

// ==== sample_stream_if.sv ====
// Valid/ready stream carrying conversion samples between modules.
// Assumes producer and consumer share one clock.
`timescale 1ns/1ps
`default_nettype none
interface sample_stream_if #(parameter int W = 24);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sample_stream_if
`default_nettype wire
